//--- src/pivm_pkg.sv
// constants, field layouts and reset values of the interrupt vector/mask block
// Functional notes
// R01 - bit 5 low source: calibration request pending
// R02 - bit 4 low source: lifespan counter pending
// R03 - bit 3 low source: measurement done pending
// R04 - bits 2..0 receive/transmit/error; 7:6 zero
// R05 - vector bits 4:0 hold highest pending code
// R06 - vector 0x00 when nothing pending
// R07 - undervoltage 0x01 highest, overheat 0x02, line 0x03
// R08 - timer 0x04..0x08, serial 0x09..0x0B, descending
// R09 - measurement 0x0C, lifespan 0x0D, calibration 0x0E lowest
// R10 - high disable register 0x0C, 1 disables
// R11 - low disable register 0x0D, 7:6 zero
// R12 - windows at 0x0E00 blocking, 0x0F00 non-blocking
// R13 - high source register at 0x08
// R14 - measurement done from current or voltage
// R15 - one request line from unmasked pending sources
// R16 - source flags mirror inputs; writes ignored
package pivm_pkg;

	// ==========================================
	// global address windows
	localparam logic [7:0]  PIVM_WIN_BLOCKING    = 8'h0E;   // upper address byte, blocking window
	localparam logic [7:0]  PIVM_WIN_NONBLOCKING = 8'h0F;   // upper address byte, non-blocking window

	// ==========================================
	// register offsets inside a window
	localparam logic [7:0]  PIVM_OFS_SRC_HI  = 8'h08;       // pending_source_high
	localparam logic [7:0]  PIVM_OFS_SRC_LO  = 8'h09;       // pending_source_low
	localparam logic [7:0]  PIVM_OFS_VECT    = 8'h0A;       // active_vector
	localparam logic [7:0]  PIVM_OFS_RSVD    = 8'h0B;       // reserved, reads zero
	localparam logic [7:0]  PIVM_OFS_DIS_HI  = 8'h0C;       // source_disable_high
	localparam logic [7:0]  PIVM_OFS_DIS_LO  = 8'h0D;       // source_disable_low

	// ==========================================
	// widths and reset values
	localparam int          PIVM_NUM_SRC     = 14;          // number of interrupt sources
	localparam int          PIVM_LO_BITS     = 6;           // implemented bits of the low registers
	localparam int          PIVM_VECT_BITS   = 5;           // vector code width
	localparam logic [7:0]  PIVM_DIS_HI_RST  = 8'h00;       // all high sources enabled
	localparam logic [7:0]  PIVM_DIS_LO_RST  = 8'h00;       // all low sources enabled
	localparam logic [7:0]  PIVM_RDATA_RST   = 8'h00;       // read data after reset
	localparam logic [4:0]  PIVM_VECT_NONE   = 5'h00;       // no source pending / stop wake-up

	// ==========================================
	// bit positions in the combined 14-bit source vector; index + 1 is the code
	localparam int          PIVM_B_UNDERVOLT = 0;           // code 0x01, highest priority
	localparam int          PIVM_B_OVERHEAT  = 1;           // code 0x02
	localparam int          PIVM_B_LINEDRV   = 2;           // code 0x03
	localparam int          PIVM_B_CHAN0     = 3;           // code 0x04
	localparam int          PIVM_B_CHAN1     = 4;           // code 0x05
	localparam int          PIVM_B_CHAN2     = 5;           // code 0x06
	localparam int          PIVM_B_CHAN3     = 6;           // code 0x07
	localparam int          PIVM_B_TWRAP     = 7;           // code 0x08
	localparam int          PIVM_B_SFAULT    = 8;           // code 0x09
	localparam int          PIVM_B_STX       = 9;           // code 0x0A
	localparam int          PIVM_B_SRX       = 10;          // code 0x0B
	localparam int          PIVM_B_MEAS      = 11;          // code 0x0C
	localparam int          PIVM_B_LIFE      = 12;          // code 0x0D
	localparam int          PIVM_B_RECAL     = 13;          // code 0x0E, lowest priority

	// ==========================================
	// access kinds seen by the decoder
	typedef enum logic [1:0] {
		PIVM_ACC_NONE,
		PIVM_ACC_BLOCKING,
		PIVM_ACC_NONBLOCKING
	} pivm_acc_t;

endpackage : pivm_pkg

//--- src/pivm_prio_enc.sv
// fixed-priority encoder: lowest set index wins, code is index plus one
`timescale 1ns/10ps
module pivm_prio_enc #(
	parameter int NUM_SRC   = 14,                           // number of request lines
	parameter int CODE_BITS = 5                             // width of the code
) (
	input  wire logic [NUM_SRC-1:0]   req_i,                // enabled pending requests
	output logic      [CODE_BITS-1:0] code_o,               // winning code, zero when idle
	output logic                      any_o                 // at least one request
);
	import pivm_pkg::*;

	// ==========================================
	// ripple chain from the lowest priority end toward index 0
	logic [CODE_BITS-1:0] chain [NUM_SRC:0];                // partial result per stage

	assign chain[NUM_SRC] = CODE_BITS'(PIVM_VECT_NONE);     // nothing pending gives zero, see R06

	// each stage overrides everything behind it, so index 0 is strongest;
	// counting up keeps the genvar non-negative, stage order does not matter
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_stage
			localparam logic [CODE_BITS-1:0] CODE = CODE_BITS'(g + 1);   // code of this source
			assign chain[g] = req_i[g] ? CODE : chain[g+1];  // see R05 see R07 see R08 see R09
		end
	endgenerate

	assign code_o = chain[0];
	assign any_o  = |req_i;                                  // single request line, see R15

endmodule : pivm_prio_enc

//--- src/pivm_addr_dec.sv
// address window decoder for the blocking and non-blocking register windows
`timescale 1ns/10ps
module pivm_addr_dec (
	input  wire logic [15:0]          addr_i,               // global address from the core
	output pivm_pkg::pivm_acc_t       kind_o,               // which window matched
	output logic      [7:0]           offset_o              // offset inside the window
);
	import pivm_pkg::*;

	// ==========================================
	// upper byte selects window, lower byte is the register offset
	always_comb begin
		offset_o = addr_i[7:0];
		if (addr_i[15:8] == PIVM_WIN_BLOCKING) begin          // see R12
			kind_o = PIVM_ACC_BLOCKING;
		end else if (addr_i[15:8] == PIVM_WIN_NONBLOCKING) begin   // see R12
			kind_o = PIVM_ACC_NONBLOCKING;
		end else begin
			kind_o = PIVM_ACC_NONE;
		end
	end

endmodule : pivm_addr_dec

//--- src/pivm_top.sv
// interrupt source collection, masking and priority vector with register window
`timescale 1ns/10ps
module pivm_top (
	// ==========================================
	// clock, reset, enable
	input  wire logic        clock_i,                       // 40 MHz system clock
	input  wire logic        sys_rst_i,                     // synchronous, active high
	input  wire logic        clk_en_i,                      // low freezes all state

	// ==========================================
	// source requests, levels held by the source modules
	input  wire logic        undervoltage_event_i,          // undervoltage or cranking wake
	input  wire logic        overheat_event_i,              // high temperature
	input  wire logic        line_driver_fault_event_i,     // driver overtemp or dominant timeout
	input  wire logic        timer_chan0_event_i,           // timer channel 0
	input  wire logic        timer_chan1_event_i,           // timer channel 1
	input  wire logic        timer_chan2_event_i,           // timer channel 2
	input  wire logic        timer_chan3_event_i,           // timer channel 3
	input  wire logic        timer_wrap_event_i,            // timer overflow
	input  wire logic        serial_fault_event_i,          // serial error
	input  wire logic        serial_transmit_event_i,       // serial transmit
	input  wire logic        serial_receive_event_i,        // serial receive
	input  wire logic        current_meas_done_i,           // current measurement finished
	input  wire logic        voltage_meas_done_i,           // voltage measurement finished
	input  wire logic        lifespan_counter_event_i,      // lifespan counter overflow
	input  wire logic        recalibration_event_i,         // calibration request

	// ==========================================
	// register access from the core
	input  wire logic [15:0] reg_addr_i,                    // global address
	input  wire logic        reg_rd_i,                      // read strobe, one cycle
	input  wire logic        reg_wr_i,                      // write strobe, one cycle
	input  wire logic [7:0]  reg_wdata_i,                   // write data
	output logic      [7:0]  reg_rdata_o,                   // read data, registered
	output logic             reg_rvalid_o,                  // read data valid pulse
	output logic             reg_hit_o,                     // last read, or a later write, hit a window
	output logic             reg_nonblocking_o,             // last read, or a later hitting write, used the non-blocking window

	// ==========================================
	// towards the core
	output logic             irq_o,                         // any enabled source pending
	output logic      [4:0]  vector_o                       // current vector code
);
	import pivm_pkg::*;

	// ==========================================
	// all state of the block in one record
	typedef struct packed {
		logic [7:0]                 pend_hi;                // high source mirror
		logic [PIVM_LO_BITS-1:0]    pend_lo;                // low source mirror
		logic [7:0]                 dis_hi;                 // high disable bits
		logic [PIVM_LO_BITS-1:0]    dis_lo;                 // low disable bits
		logic [PIVM_VECT_BITS-1:0]  vect;                   // registered vector code
		logic                       irq;                    // registered request line
		logic [7:0]                 rdata;                  // read data holding register
		logic                       rvalid;                 // read answer pulse
		logic                       hit;                    // last read or hitting write decoded
		logic                       nonblk;                 // window kind of the last read or hitting write
	} pivm_state_t;

	pivm_state_t state_ff;                                   // registered state
	pivm_state_t nxt_state;                                  // next state

	// ==========================================
	// combined source vector, bit index + 1 equals the vector code
	logic [PIVM_NUM_SRC-1:0]    raw_src;                    // live source levels
	logic [PIVM_NUM_SRC-1:0]    pend_all;                   // registered pending flags
	logic [PIVM_NUM_SRC-1:0]    dis_all;                    // registered disable bits
	logic [PIVM_NUM_SRC-1:0]    enabled_pend;               // pending and not disabled
	logic [PIVM_VECT_BITS-1:0]  enc_code;                   // encoder result
	logic                       enc_any;                    // encoder any-request
	pivm_acc_t                  acc_kind;                   // decoded window
	logic [7:0]                 acc_offset;                 // decoded offset
	logic                       acc_hit;                    // address falls in a window

	// ==========================================
	// source gathering
	// measurement done is one flag for both kinds of measurement
	always_comb begin
		raw_src                   = '0;
		raw_src[PIVM_B_UNDERVOLT] = undervoltage_event_i;
		raw_src[PIVM_B_OVERHEAT]  = overheat_event_i;
		raw_src[PIVM_B_LINEDRV]   = line_driver_fault_event_i;
		raw_src[PIVM_B_CHAN0]     = timer_chan0_event_i;
		raw_src[PIVM_B_CHAN1]     = timer_chan1_event_i;
		raw_src[PIVM_B_CHAN2]     = timer_chan2_event_i;
		raw_src[PIVM_B_CHAN3]     = timer_chan3_event_i;
		raw_src[PIVM_B_TWRAP]     = timer_wrap_event_i;
		raw_src[PIVM_B_SFAULT]    = serial_fault_event_i;
		raw_src[PIVM_B_STX]       = serial_transmit_event_i;
		raw_src[PIVM_B_SRX]       = serial_receive_event_i;
		raw_src[PIVM_B_MEAS]      = current_meas_done_i | voltage_meas_done_i;   // see R14
		raw_src[PIVM_B_LIFE]      = lifespan_counter_event_i;
		raw_src[PIVM_B_RECAL]     = recalibration_event_i;
	end

	// ==========================================
	// masking of the registered flags
	// the high register fills bits 7..0, the low register bits 13..8
	assign pend_all     = {state_ff.pend_lo, state_ff.pend_hi};
	assign dis_all      = {state_ff.dis_lo, state_ff.dis_hi};
	assign enabled_pend = pend_all & ~dis_all;               // 1 disables a source, see R15

	// ==========================================
	// priority encoder: lowest index is highest priority
	pivm_prio_enc #(
		.NUM_SRC   (PIVM_NUM_SRC),
		.CODE_BITS (PIVM_VECT_BITS)
	) u_prio (
		.req_i     (enabled_pend),
		.code_o    (enc_code),
		.any_o     (enc_any)
	);

	// ==========================================
	// window decode of the core address
	pivm_addr_dec u_dec (
		.addr_i    (reg_addr_i),
		.kind_o    (acc_kind),
		.offset_o  (acc_offset)
	);

	assign acc_hit = (acc_kind != PIVM_ACC_NONE);            // either window, see R12

	// ==========================================
	// next-state logic
	// the vector and request lag the flags by one cycle, which keeps
	// every output on a flip-flop at the cost of one cycle of latency
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.rvalid = 1'b0;                             // answer is a single pulse

		// flags simply follow the sources; only a source withdrawing or sys_rst_i clears them
		nxt_state.pend_hi = raw_src[7:0];                    // see R13 see R16
		nxt_state.pend_lo = raw_src[PIVM_NUM_SRC-1:8];       // see R01 see R02 see R03 see R04 see R16

		// vector and request derived from the current enabled flags
		nxt_state.vect = enc_code;                           // see R05 see R06
		nxt_state.irq  = enc_any;                            // see R15

		// writes: only the two disable registers take data
		if (reg_wr_i && acc_hit) begin
			nxt_state.hit    = 1'b1;
			nxt_state.nonblk = (acc_kind == PIVM_ACC_NONBLOCKING);
			case (acc_offset)
				PIVM_OFS_DIS_HI: begin
					nxt_state.dis_hi = reg_wdata_i;              // see R10
				end
				PIVM_OFS_DIS_LO: begin
					nxt_state.dis_lo = reg_wdata_i[PIVM_LO_BITS-1:0];   // see R11
				end
				default: begin
					// source, vector and reserved bytes ignore writes, see R16
				end
			endcase
		end

		// reads: registered data, answered one cycle after the strobe
		if (reg_rd_i) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.hit    = acc_hit;
			nxt_state.nonblk = (acc_kind == PIVM_ACC_NONBLOCKING);
			nxt_state.rdata  = PIVM_RDATA_RST;               // unmapped reads return zero
			if (acc_hit) begin
				case (acc_offset)
					PIVM_OFS_SRC_HI: begin
						nxt_state.rdata = state_ff.pend_hi;      // see R13
					end
					PIVM_OFS_SRC_LO: begin
						nxt_state.rdata = {2'b00, state_ff.pend_lo};   // see R01 see R02 see R03 see R04
					end
					PIVM_OFS_VECT: begin
						nxt_state.rdata = {3'b000, state_ff.vect};     // see R05
					end
					PIVM_OFS_RSVD: begin
						nxt_state.rdata = PIVM_RDATA_RST;        // reserved byte
					end
					PIVM_OFS_DIS_HI: begin
						nxt_state.rdata = state_ff.dis_hi;       // see R10
					end
					PIVM_OFS_DIS_LO: begin
						nxt_state.rdata = {2'b00, state_ff.dis_lo};    // see R11
					end
					default: begin
						nxt_state.rdata = PIVM_RDATA_RST;
					end
				endcase
			end
		end
	end

	// ==========================================
	// state register with synchronous reset and clock enable
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_ff.pend_hi <= '0;
			state_ff.pend_lo <= '0;
			state_ff.dis_hi  <= PIVM_DIS_HI_RST;
			state_ff.dis_lo  <= PIVM_DIS_LO_RST[PIVM_LO_BITS-1:0];
			state_ff.vect    <= PIVM_VECT_NONE;
			state_ff.irq     <= 1'b0;
			state_ff.rdata   <= PIVM_RDATA_RST;
			state_ff.rvalid  <= 1'b0;
			state_ff.hit     <= 1'b0;
			state_ff.nonblk  <= 1'b0;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================
	// outputs straight from the state record
	assign reg_rdata_o       = state_ff.rdata;
	assign reg_rvalid_o      = state_ff.rvalid;
	assign reg_hit_o         = state_ff.hit;
	assign reg_nonblocking_o = state_ff.nonblk;
	assign irq_o             = state_ff.irq;
	assign vector_o          = state_ff.vect;

endmodule : pivm_top

//--- tb/pivm_top_sva.sv
// port-level assertion checker for the interrupt vector/mask block
`timescale 1ns/10ps
module pivm_top_sva (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        undervoltage_event_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic [7:0]  reg_rdata_o,
	input  wire logic        reg_rvalid_o,
	input  wire logic        reg_hit_o,
	input  wire logic        reg_nonblocking_o,
	input  wire logic        irq_o,
	input  wire logic [4:0]  vector_o
);
	// ==========================================
	// shadow of the disable registers, rebuilt from port writes
	logic [7:0] dis_hi_ff;  // expected disable high
	logic [7:0] dis_lo_ff;  // expected disable low, bits 7:6 dropped
	logic       win;        // address inside either window
	assign win = (reg_addr_i[15:8] == 8'h0E) || (reg_addr_i[15:8] == 8'h0F);
	// shadow follows only taken writes, so a frozen clock enable is honoured
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			dis_hi_ff <= 8'h00;
			dis_lo_ff <= 8'h00;
		end else if (clk_en_i && reg_wr_i && win) begin
			if (reg_addr_i[7:0] == 8'h0C) dis_hi_ff <= reg_wdata_i;
			if (reg_addr_i[7:0] == 8'h0D) dis_lo_ff <= {2'b00, reg_wdata_i[5:0]};
		end
	end
	// ==========================================
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_rd(logic [7:0] ofs); clk_en_i && reg_rd_i && win && reg_addr_i[7:0] == ofs; endsequence
	sequence s_uv_held; (clk_en_i && undervoltage_event_i && !dis_hi_ff[0])[*2]; endsequence
	property p_rd_answer; clk_en_i && reg_rd_i |=> reg_rvalid_o; endproperty
	property p_no_spurious; clk_en_i && !reg_rd_i |=> !reg_rvalid_o; endproperty
	property p_irq_vs_vector; irq_o == (vector_o != 5'h00); endproperty
	property p_vector_range; vector_o <= 5'h0E; endproperty
	property p_uv_wins; s_uv_held |=> vector_o == 5'h01 && irq_o; endproperty
	property p_all_masked; clk_en_i && dis_hi_ff == 8'hFF && dis_lo_ff == 8'h3F |=> !irq_o; endproperty
	property p_lo_top_zero; s_rd(8'h09) |=> reg_rdata_o[7:6] == 2'b00; endproperty
	property p_vect_read; s_rd(8'h0A) |=> reg_rdata_o == {3'b000, $past(vector_o)}; endproperty
	property p_dis_hi_read; s_rd(8'h0C) |=> reg_rdata_o == $past(dis_hi_ff); endproperty
	property p_dis_lo_read; s_rd(8'h0D) |=> reg_rdata_o == $past(dis_lo_ff); endproperty
	property p_unmapped; clk_en_i && reg_rd_i && !win |=> reg_rdata_o == 8'h00 && !reg_hit_o; endproperty
	property p_nonblk; clk_en_i && reg_rd_i && reg_addr_i[15:8] == 8'h0F |=> reg_hit_o && reg_nonblocking_o; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read without answer");
	a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
	a_irq_vs_vector: assert property (p_irq_vs_vector) else $error("irq and vector disagree");
	a_vector_range: assert property (p_vector_range) else $error("vector code out of range");
	a_uv_wins: assert property (p_uv_wins) else $error("undervoltage not on top");
	a_all_masked: assert property (p_all_masked) else $error("irq while all disabled");
	a_lo_top_zero: assert property (p_lo_top_zero) else $error("low source top bits set");
	a_vect_read: assert property (p_vect_read) else $error("vector read mismatch");
	a_dis_hi_read: assert property (p_dis_hi_read) else $error("disable high readback");
	a_dis_lo_read: assert property (p_dis_lo_read) else $error("disable low readback");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not empty");
	a_nonblk: assert property (p_nonblk) else $error("second window not flagged");
endmodule : pivm_top_sva

//--- tb/pivm_core_model.sv
// model of the core that reads and writes the register windows
`timescale 1ns/10ps
module pivm_core_model (
	input  wire logic        clock_i,
	input  wire logic [7:0]  reg_rdata_i,
	input  wire logic        reg_rvalid_i,
	output logic      [15:0] reg_addr_o,
	output logic             reg_rd_o,
	output logic             reg_wr_o,
	output logic      [7:0]  reg_wdata_o
);
	// ==========================================
	// idle bus at time zero
	initial begin
		reg_addr_o  = 16'h0000;
		reg_rd_o    = 1'b0;
		reg_wr_o    = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// one-cycle write strobe; data scrambled after so stale data never helps
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		reg_addr_o  = a;
		reg_wdata_o = d;
		reg_wr_o    = 1'b1;
		@(posedge clock_i);
		#1;
		reg_wr_o    = 1'b0;
		reg_wdata_o = ~d;
	endtask : wr
	// one-cycle read strobe; answer taken one cycle after the strobe was driven
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge clock_i);
		#1;
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(posedge clock_i);
		#1;
		reg_rd_o   = 1'b0;
		v          = reg_rvalid_i;
		d          = reg_rdata_i;
	endtask : rd
endmodule : pivm_core_model

//--- tb/tb_pivm_top.sv
// self-checking bench for the interrupt vector/mask block
`timescale 1ns/10ps
module tb_pivm_top;
	import pivm_pkg::*;
	// ==========================================
	// stimulus rows: sources, disables, expected vector
	typedef struct packed {logic [14:0] s; logic [7:0] dh; logic [7:0] dl; logic [4:0] v;} pivm_row_t;
	pivm_row_t   rows [9] = '{'{15'h0000, 8'h00, 8'h00, 5'h00}, '{15'h7FFF, 8'h00, 8'h00, 5'h01},
		'{15'h7FFF, 8'hFF, 8'h00, 5'h09}, '{15'h7FFF, 8'hFF, 8'h3F, 5'h00}, '{15'h0006, 8'h02, 8'h00, 5'h03},
		'{15'h7F00, 8'hFF, 8'h01, 5'h0A}, '{15'h1000, 8'h00, 8'h00, 5'h0C}, '{15'h6000, 8'h00, 8'h10, 5'h0E},
		'{15'h0180, 8'h7F, 8'h00, 5'h08}};
	logic        clock_i   = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        clk_en_i  = 1'b1;
	logic [14:0] src       = 15'h0000; // source levels, bit n is code n+1 up to bit 11, code n above
	logic [15:0] addr;
	logic        rd, wr, rvalid, hit, nonblk, irq;
	logic [7:0]  wdata, rdata;
	logic [4:0]  vect;
	int          miscompares = 0;
	int          n_compared  = 0;
	always #12.5 clock_i = ~clock_i;
	pivm_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
		.undervoltage_event_i(src[0]), .overheat_event_i(src[1]), .line_driver_fault_event_i(src[2]),
		.timer_chan0_event_i(src[3]), .timer_chan1_event_i(src[4]), .timer_chan2_event_i(src[5]),
		.timer_chan3_event_i(src[6]), .timer_wrap_event_i(src[7]), .serial_fault_event_i(src[8]),
		.serial_transmit_event_i(src[9]), .serial_receive_event_i(src[10]), .current_meas_done_i(src[11]),
		.voltage_meas_done_i(src[12]), .lifespan_counter_event_i(src[13]), .recalibration_event_i(src[14]),
		.reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .reg_hit_o(hit), .reg_nonblocking_o(nonblk), .irq_o(irq), .vector_o(vect));
	pivm_core_model core (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
		.reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));
	// ==========================================
	// compare, read-and-compare, verdict
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		core.rd(a, d, v);
		chk({name, " valid"}, {7'h00, v}, 8'h01);
		chk(name, d, exp);
	endtask : rchk
	task automatic end_of_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// sources and disables set, then outputs and every register except the reserved byte read back
	task automatic apply(input logic [14:0] s, input logic [7:0] dh, input logic [7:0] dl,
		input logic [4:0] ev, input logic [15:0] b);
		@(posedge clock_i);
		#1;
		src = s;
		core.wr(b | 16'h000C, dh);
		core.wr(b | 16'h000D, dl);
		repeat (2) @(posedge clock_i);
		#1;
		chk("vector", {3'b000, vect}, {3'b000, ev});
		chk("irq", {7'h00, irq}, {7'h00, ev != 5'h00});
		rchk("src_hi", b | 16'h0008, s[7:0]);
		rchk("src_lo", b | 16'h0009, {2'b00, s[14:13], s[11] | s[12], s[10:8]});
		rchk("vect_reg", b | 16'h000A, {3'b000, ev});
		rchk("dis_hi", b | 16'h000C, dh);
		rchk("dis_lo", b | 16'h000D, {2'b00, dl[5:0]});
	endtask : apply
	// ==========================================
	// hang guard, far beyond the few hundred cycles the run takes
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge clock_i);
		#1;
		sys_rst_i = 1'b0;
		rchk("dis_hi_rst", 16'h0E0C, 8'h00);
		rchk("dis_lo_rst", 16'h0F0D, 8'h00);
		foreach (rows[i]) apply(rows[i].s, rows[i].dh, rows[i].dl, rows[i].v, i[0] ? 16'h0F00 : 16'h0E00);
		for (int i = 0; i < 15; i++) apply(15'h0001 << i, 8'h00, 8'h00, 5'((i <= 11) ? i + 1 : i), 16'h0E00);
		// read-only places ignore writes, calibration still pending
		core.wr(16'h0E09, 8'hFF);
		core.wr(16'h0F0A, 8'hFF);
		core.wr(16'h0E0B, 8'hFF);
		rchk("src_lo_ro", 16'h0E09, 8'h20);
		rchk("vect_ro", 16'h0F0A, 8'h0E);
		chk("nonblk", {6'h00, hit, nonblk}, 8'h03);
		rchk("reserved", 16'h0E0B, 8'h00);
		chk("blk", {6'h00, hit, nonblk}, 8'h02);
		// outside the windows: write dropped, read empty and not a hit
		core.wr(16'h0D0C, 8'hFF);
		rchk("outside", 16'h1009, 8'h00);
		chk("hit", {7'h00, hit}, 8'h00);
		rchk("dis_hi_out", 16'h0F0C, 8'h00);
		// top bits of the low disable are not kept
		core.wr(16'h0F0D, 8'hFF);
		rchk("dis_lo_top", 16'h0E0D, 8'h3F);
		chk("irq_masked", {7'h00, irq}, 8'h00);
		// frozen enable holds the vector, release lets undervoltage win
		@(posedge clock_i);
		#1;
		clk_en_i = 1'b0;
		src      = 15'h0001;
		repeat (4) @(posedge clock_i);
		#1;
		chk("frozen", {3'b000, vect}, 8'h00);
		clk_en_i = 1'b1;
		repeat (3) @(posedge clock_i);
		#1;
		chk("unfrozen", {3'b000, vect}, 8'h01);
		// second reset in mid-run clears outputs and disables
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1;
		sys_rst_i = 1'b0;
		chk("vect_rerst", {3'b000, vect}, 8'h00);
		rchk("dis_lo_rerst", 16'h0E0D, 8'h00);
		end_of_test();
	end
endmodule : tb_pivm_top
bind pivm_top pivm_top_sva u_sva (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
	.undervoltage_event_i(undervoltage_event_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.reg_hit_o(reg_hit_o), .reg_nonblocking_o(reg_nonblocking_o), .irq_o(irq_o), .vector_o(vector_o));
